// ### vme_slave_defines.svh
`ifndef VME_SLAVE_DEFINES_SVH
`define VME_SLAVE_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses from the register base)
// ----------------------------------------------------------------
`define BOUNDS_ONE_OFS 5'h00
`define BOUNDS_TWO_OFS 5'h04
`define XLATE_ONE_OFS 5'h08
`define XLATE_TWO_OFS 5'h0C
`define CONTROL_OFS 5'h10

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define WORD_RESET 32'h0000_0000
`define CTL_MASK 32'h0FFF_0FFF

// ----------------------------------------------------------------
// control word field positions
// ----------------------------------------------------------------
`define CTL_ONE_LSB 0
`define CTL_TWO_LSB 16
`define AMSEL_W 8
`define WP_ONE_BIT 8
`define ADDER_ONE_BIT 11
`define WP_TWO_BIT 24
`define ADDER_TWO_BIT 27

// ----------------------------------------------------------------
// address modifier decode
// ----------------------------------------------------------------
`define AM_WIDTH_A32 3'h1
`define AM_WIDTH_A24 3'h7
`define AM_KIND_D64 2'h0
`define AM_KIND_DAT 2'h1
`define AM_KIND_PGM 2'h2
`define AM_KIND_BLK 2'h3

// ----------------------------------------------------------------
// register access sizes
// ----------------------------------------------------------------
`define SIZE_WORD 2'h2

`endif

// ### vme_slave_pkg.sv
package vme_slave_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CLAIM = 3'b010,
    ST_SKIP = 3'b100
  } cycle_state_t;

  typedef logic [15:0] half_word_t;

endpackage

// ### sync_two_stage.sv
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage <= '0;
      q_o <= '0;
    end else begin
      stage <= d_i;
      q_o <= stage;
    end
  end

endmodule

// ### slave_window_decoder.sv
`include "vme_slave_defines.svh"

module slave_window_decoder (
  input wire logic [31:0] addr_i,
  input wire logic [5:0] am_i,
  input wire logic [15:0] start_addr_i,
  input wire logic [15:0] end_addr_i,
  input wire logic [15:0] value_i,
  input wire logic [15:0] mask_i,
  input wire logic [`AMSEL_W-1:0] amsel_i,
  input wire logic adder_en_i,
  output logic hit_o,
  output logic [31:0] local_addr_o
);

  logic is_a24;
  logic is_a32;
  logic [3:0] kind;
  logic enabled;
  logic am_ok;
  logic in_range;
  vme_slave_pkg::half_word_t upper;
  vme_slave_pkg::half_word_t replaced;
  vme_slave_pkg::half_word_t summed;

  assign is_a24 = (am_i[5:3] == `AM_WIDTH_A24);
  assign is_a32 = (am_i[5:3] == `AM_WIDTH_A32);

  always_comb begin
    kind = 4'h0;
    case (am_i[1:0])
      `AM_KIND_DAT: kind[0] = 1'b1;
      `AM_KIND_PGM: kind[1] = 1'b1;
      `AM_KIND_BLK: kind[2] = 1'b1;
      default: kind[3] = 1'b1;
    endcase
  end

  // all selects clear means no response at all
  assign enabled = (|amsel_i[3:0]) & (|amsel_i[5:4]) & (|amsel_i[7:6]);
  assign am_ok = (|(kind & amsel_i[3:0]))
    & ((is_a24 & amsel_i[4]) | (is_a32 & amsel_i[5]))
    & (am_i[2] ? amsel_i[7] : amsel_i[6]);

  // short addressing sees the top byte as zero
  assign upper = is_a24 ? {8'h00, addr_i[23:16]} : addr_i[31:16];
  assign in_range = (upper >= start_addr_i) && (upper <= end_addr_i);
  assign hit_o = enabled & am_ok & in_range;

  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_replace
      if (b >= 8) begin : g_high
        assign replaced[b] = (mask_i[b] | is_a24) ? value_i[b] : upper[b];
      end else begin : g_low
        assign replaced[b] = mask_i[b] ? value_i[b] : upper[b];
      end
    end
  endgenerate

  assign summed = value_i + upper;

  // adder bit picks the scheme; low half never altered
  assign local_addr_o = {adder_en_i ? summed : replaced, addr_i[15:0]};

endmodule

// ### vme_slave_map.sv
// Functional notes
// - two independent windows map bus segments of 64KB to 4GB onto local bus.
// - translation builds top 16 local bits from the translation word and the bus address.
// - both windows come out of any reset disabled.
// - short addressing cycles see top eight address bits as zero before compare.
// - all modifier selects clear means the window answers nothing.
// - only local bits 31..16 are translated; low bits pass unchanged.
// - short cycles with adder off take top eight local lines from the translation value.
// - set mask bit takes the value bit, clear takes the bus bit.
// - with adder on, local 31..16 is offset plus bus 31..16.
// - short cycles zero bus bits 31..24 before the addition.
// - adder enables are control bits 11 and 27 at offset 0x10.
// - both adders are off after reset.
// - write posting only while the window's post enable bit is set.
// - bounds word holds end in 31..16, start in 15..0.
// - upper translation half is replacement value and adder offset.
// - a window needs one select in each of kind, width and privilege.
// - post enables are control bits 8 and 24, cleared by reset.
`include "vme_slave_defines.svh"

module vme_slave_map #(
  parameter int ADDR_W = 32,
  parameter int AM_W = 6
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [1:0] reg_size_i,
  input wire logic [31:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic reg_err_o,
  output logic [31:0] reg_rdata_o,
  input wire logic [ADDR_W-1:0] vme_addr_i,
  input wire logic [AM_W-1:0] vme_am_i,
  input wire logic vme_as_n_i,
  input wire logic vme_write_n_i,
  output logic claim_one_o,
  output logic claim_two_o,
  output logic [31:0] local_addr_o,
  output logic post_write_o
);

  if (ADDR_W != 32 || AM_W != 6) begin : g_bad_width
    $error("vme_slave_map supports only 32 address and 6 modifier bits");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] bounds_one;
  logic [31:0] bounds_two;
  logic [31:0] xlate_one;
  logic [31:0] xlate_two;
  logic [31:0] ctl;
  logic [31:0] next_bounds_one;
  logic [31:0] next_bounds_two;
  logic [31:0] next_xlate_one;
  logic [31:0] next_xlate_two;
  logic [31:0] next_ctl;
  logic next_ack;
  logic next_err;
  logic [31:0] next_rdata;
  logic wr_ok;

  function automatic logic at_ofs(input logic [4:0] a, input logic [4:0] ofs);
    at_ofs = (a == ofs);
  endfunction

  // narrow writes are refused with an error, wide reads of any size
  assign wr_ok = reg_req_i && reg_wr_i && (reg_size_i == `SIZE_WORD);

  always_comb begin
    next_bounds_one = bounds_one;
    next_bounds_two = bounds_two;
    next_xlate_one = xlate_one;
    next_xlate_two = xlate_two;
    next_ctl = ctl;
    next_ack = reg_req_i && !(reg_wr_i && reg_size_i != `SIZE_WORD);
    next_err = reg_req_i && reg_wr_i && (reg_size_i != `SIZE_WORD);
    next_rdata = reg_rdata_o;
    if (wr_ok) begin
      if (at_ofs(reg_addr_i, `BOUNDS_ONE_OFS)) next_bounds_one = reg_wdata_i;
      if (at_ofs(reg_addr_i, `BOUNDS_TWO_OFS)) next_bounds_two = reg_wdata_i;
      if (at_ofs(reg_addr_i, `XLATE_ONE_OFS)) next_xlate_one = reg_wdata_i;
      if (at_ofs(reg_addr_i, `XLATE_TWO_OFS)) next_xlate_two = reg_wdata_i;
      if (at_ofs(reg_addr_i, `CONTROL_OFS)) next_ctl = reg_wdata_i & `CTL_MASK;
    end
    if (reg_req_i && !reg_wr_i) begin
      next_rdata = 32'h0000_0000;
      if (at_ofs(reg_addr_i, `BOUNDS_ONE_OFS)) next_rdata = bounds_one;
      if (at_ofs(reg_addr_i, `BOUNDS_TWO_OFS)) next_rdata = bounds_two;
      if (at_ofs(reg_addr_i, `XLATE_ONE_OFS)) next_rdata = xlate_one;
      if (at_ofs(reg_addr_i, `XLATE_TWO_OFS)) next_rdata = xlate_two;
      if (at_ofs(reg_addr_i, `CONTROL_OFS)) next_rdata = ctl;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bounds_one <= `WORD_RESET;
      bounds_two <= `WORD_RESET;
      xlate_one <= `WORD_RESET;
      xlate_two <= `WORD_RESET;
      ctl <= `WORD_RESET;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      bounds_one <= next_bounds_one;
      bounds_two <= next_bounds_two;
      xlate_one <= next_xlate_one;
      xlate_two <= next_xlate_two;
      ctl <= next_ctl;
      reg_ack_o <= next_ack;
      reg_err_o <= next_err;
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // bus input synchronisers
  // ----------------------------------------------------------------
  logic [31:0] addr_s;
  logic [5:0] am_s;
  logic as_n_s;
  logic write_n_s;

  sync_two_stage #(.WIDTH(40)) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({vme_addr_i, vme_am_i, vme_as_n_i, vme_write_n_i}),
    .q_o({addr_s, am_s, as_n_s, write_n_s})
  );

  // ----------------------------------------------------------------
  // the two window decoders
  // ----------------------------------------------------------------
  logic hit_one;
  logic hit_two;
  logic [31:0] xaddr_one;
  logic [31:0] xaddr_two;

  slave_window_decoder u_dec_one (
    .addr_i(addr_s),
    .am_i(am_s),
    .start_addr_i(bounds_one[15:0]),
    .end_addr_i(bounds_one[31:16]),
    .value_i(xlate_one[31:16]),
    .mask_i(xlate_one[15:0]),
    .amsel_i(ctl[`CTL_ONE_LSB +: `AMSEL_W]),
    .adder_en_i(ctl[`ADDER_ONE_BIT]),
    .hit_o(hit_one),
    .local_addr_o(xaddr_one)
  );

  slave_window_decoder u_dec_two (
    .addr_i(addr_s),
    .am_i(am_s),
    .start_addr_i(bounds_two[15:0]),
    .end_addr_i(bounds_two[31:16]),
    .value_i(xlate_two[31:16]),
    .mask_i(xlate_two[15:0]),
    .amsel_i(ctl[`CTL_TWO_LSB +: `AMSEL_W]),
    .adder_en_i(ctl[`ADDER_TWO_BIT]),
    .hit_o(hit_two),
    .local_addr_o(xaddr_two)
  );

  // ----------------------------------------------------------------
  // cycle claim sequencer
  // ----------------------------------------------------------------
  vme_slave_pkg::cycle_state_t state;
  vme_slave_pkg::cycle_state_t next_state;
  logic next_claim_one;
  logic next_claim_two;
  logic [31:0] next_local_addr;
  logic next_post;

  // decision taken once per strobe; window one wins an overlap
  always_comb begin
    next_state = state;
    next_claim_one = claim_one_o;
    next_claim_two = claim_two_o;
    next_local_addr = local_addr_o;
    next_post = post_write_o;
    case (state)
      vme_slave_pkg::ST_IDLE: begin
        if (!as_n_s) begin
          if (hit_one) begin
            next_state = vme_slave_pkg::ST_CLAIM;
            next_claim_one = 1'b1;
            next_local_addr = xaddr_one;
            next_post = !write_n_s && ctl[`WP_ONE_BIT];
          end else if (hit_two) begin
            next_state = vme_slave_pkg::ST_CLAIM;
            next_claim_two = 1'b1;
            next_local_addr = xaddr_two;
            next_post = !write_n_s && ctl[`WP_TWO_BIT];
          end else begin
            next_state = vme_slave_pkg::ST_SKIP;
          end
        end
      end
      vme_slave_pkg::ST_CLAIM, vme_slave_pkg::ST_SKIP: begin
        if (as_n_s) begin
          next_state = vme_slave_pkg::ST_IDLE;
          next_claim_one = 1'b0;
          next_claim_two = 1'b0;
          next_post = 1'b0;
        end
      end
      default: begin
        next_state = vme_slave_pkg::ST_IDLE;
        next_claim_one = 1'b0;
        next_claim_two = 1'b0;
        next_post = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= vme_slave_pkg::ST_IDLE;
      claim_one_o <= 1'b0;
      claim_two_o <= 1'b0;
      local_addr_o <= 32'h0000_0000;
      post_write_o <= 1'b0;
    end else begin
      state <= next_state;
      claim_one_o <= next_claim_one;
      claim_two_o <= next_claim_two;
      local_addr_o <= next_local_addr;
      post_write_o <= next_post;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic take;
  logic a32_s;
  logic a24_s;
  assign take = (state == vme_slave_pkg::ST_IDLE) && !as_n_s;
  assign a32_s = (am_s[5:3] == `AM_WIDTH_A32);
  assign a24_s = (am_s[5:3] == `AM_WIDTH_A24);

  a_reset_all_clear: assert property ($past(sys_rst_i) |-> ctl == 32'h0000_0000)
    else $error("control word not cleared by reset");
  a_no_selects_idle: assert property (take && ctl[7:0] == 8'h00 |=> !claim_one_o)
    else $error("window one claimed with no selects");
  a_groups_needed: assert property (take && !(|ctl[21:20]) |=> !claim_two_o)
    else $error("window two claimed without a width select");
  a_low_bits_pass: assert property ($rose(claim_one_o) |-> local_addr_o[15:0] == $past(addr_s[15:0]))
    else $error("low address bits altered");
  a_adder_sum: assert property (take && hit_one && ctl[11] && a32_s
    |=> local_addr_o[31:16] == 16'($past(xlate_one[31:16]) + $past(addr_s[31:16])))
    else $error("adder sum wrong");
  a_adder_short: assert property (take && hit_one && ctl[11] && a24_s
    |=> local_addr_o[31:16] == 16'($past(xlate_one[31:16]) + {8'h00, $past(addr_s[23:16])}))
    else $error("short cycle sum wrong");
  a_mask_replace: assert property (take && hit_one && !ctl[11] && a32_s
    |=> local_addr_o[31:16] == (($past(xlate_one[31:16]) & $past(xlate_one[15:0]))
      | ($past(addr_s[31:16]) & ~$past(xlate_one[15:0]))))
    else $error("mask replacement wrong");
  a_short_top_byte: assert property (take && hit_one && !ctl[11] && a24_s
    |=> local_addr_o[31:24] == $past(xlate_one[31:24]))
    else $error("short cycle top byte not from value");
  a_range_inclusive: assert property (take && hit_one && a32_s
    |-> addr_s[31:16] >= bounds_one[15:0] && addr_s[31:16] <= bounds_one[31:16])
    else $error("window one hit out of range");
  a_short_compare: assert property (take && a24_s && bounds_two[15:0] != 16'h0000
    && {8'h00, addr_s[23:16]} < bounds_two[15:0] |-> !hit_two)
    else $error("short cycle compared with top byte");
  a_post_gated: assert property (take && hit_one && !ctl[8] |=> !post_write_o ##1 1'b1)
    else $error("write posted without enable");
  a_narrow_write: assert property (reg_req_i && reg_wr_i && reg_size_i != `SIZE_WORD
    |=> reg_err_o && !reg_ack_o && $stable(ctl) && $stable(bounds_one))
    else $error("narrow write not refused");
  a_bounds_write: assert property (wr_ok && reg_addr_i == `BOUNDS_TWO_OFS
    |=> bounds_two == $past(reg_wdata_i))
    else $error("window two bounds not written");
  a_answer_follows: assert property (reg_ack_o || reg_err_o |-> $past(reg_req_i))
    else $error("register answer without request");
  // window one wins an overlap, so never both at once
  a_claim_exclusive: assert property (!(claim_one_o && claim_two_o))
    else $error("both windows claimed one cycle");
  a_post_needs_claim: assert property (post_write_o |-> claim_one_o || claim_two_o)
    else $error("post flag without a claim");

  c_claim_one: cover property ($rose(claim_one_o));
  c_claim_two: cover property ($rose(claim_two_o));
  c_adder_claim: cover property (take && hit_two && ctl[27]);
  c_posted: cover property ($rose(post_write_o));
  c_short_claim: cover property (take && hit_one && a24_s);

endmodule

// ### vme_master_model.sv
module vme_master_model (
  input wire logic clk_i,
  output logic [31:0] addr_o,
  output logic [5:0] am_o,
  output logic as_n_o,
  output logic write_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_o = 32'h0000_0000;
    am_o = 6'h00;
    as_n_o = 1'b1;
    write_n_o = 1'b1;
  end

  // address and modifier settle one cycle ahead of the strobe
  task automatic begin_cycle(input logic [31:0] a, input logic [5:0] m, input logic wr);
    @(posedge clk_i);
    addr_o <= a;
    am_o <= m;
    write_n_o <= ~wr;
    @(posedge clk_i);
    as_n_o <= 1'b0;
  endtask

  // released lines flip so that stale values are never mistaken for live ones
  task automatic end_cycle();
    @(posedge clk_i);
    as_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    addr_o <= ~addr_o;
    am_o <= ~am_o;
    write_n_o <= ~write_n_o;
  endtask
endmodule

// ### vme_slave_map_decoders_test.sv
`include "vme_slave_defines.svh"

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module vme_slave_map_decoders_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [1:0] reg_size = 2'h2;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_ack, reg_err, claim_one, claim_two, post_write;
  logic [31:0] reg_rdata, local_addr, vme_addr;
  logic [5:0] vme_am;
  logic vme_as_n, vme_write_n;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic e;

  always #2.5 ref_clk = ~ref_clk;

  vme_slave_map uut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .reg_req_i(reg_req),
    .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_size_i(reg_size), .reg_wdata_i(reg_wdata),
    .reg_ack_o(reg_ack), .reg_err_o(reg_err), .reg_rdata_o(reg_rdata), .vme_addr_i(vme_addr),
    .vme_am_i(vme_am), .vme_as_n_i(vme_as_n), .vme_write_n_i(vme_write_n),
    .claim_one_o(claim_one), .claim_two_o(claim_two), .local_addr_o(local_addr),
    .post_write_o(post_write));

  vme_master_model mdl (.clk_i(ref_clk), .addr_o(vme_addr), .am_o(vme_am),
    .as_n_o(vme_as_n), .write_n_o(vme_write_n));

  // ----------------------------------------------------------------
  // register and bus tasks
  // ----------------------------------------------------------------
  task automatic reg_io(input logic wr, input logic [4:0] a, input logic [1:0] sz,
                        input logic [31:0] d, output logic [31:0] rq, output logic re);
    int i;
    @(posedge ref_clk);
    reg_req <= 1'b1;
    reg_wr <= wr;
    reg_addr <= a;
    reg_size <= sz;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_req <= 1'b0;
    for (i = 0; i < 3; i++) begin
      @(negedge ref_clk);
      if (reg_ack === 1'b1 || reg_err === 1'b1) break;
    end
    `CHK("answer", 1'b1, reg_ack | reg_err)
    rq = reg_rdata;
    re = reg_err;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_io(1'b1, a, `SIZE_WORD, d, q, e);
    `CHK("write error", 1'b0, e)
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] ex);
    reg_io(1'b0, a, `SIZE_WORD, 32'h0000_0000, q, e);
    `CHK("read data", ex, q)
  endtask

  task automatic vme_chk(input logic [31:0] a, input logic [5:0] m, input logic w,
                         input logic [1:0] ex_claim, input logic [31:0] ex_la,
                         input logic ex_post);
    int i;
    mdl.begin_cycle(a, m, w);
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (claim_one === 1'b1 || claim_two === 1'b1) break;
    end
    `CHK("claim", ex_claim, {claim_two, claim_one})
    if (ex_claim != 2'b00) begin
      `CHK("local address", ex_la, local_addr)
      `CHK("post", ex_post, post_write)
    end
    mdl.end_cycle();
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (claim_one === 1'b0 && claim_two === 1'b0) break;
    end
    `CHK("claim release", 2'b00, {claim_two, claim_one})
    `CHK("post release", 1'b0, post_write)
  endtask

  task automatic end_test(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int k;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 5; k++) rd_chk(5'(k * 4), 32'h0000_0000);
    vme_chk(32'h0000_0000, 6'h0D, 1'b1, 2'b00, 32'h0, 1'b0);
    end_test("reset");

    wr(`BOUNDS_ONE_OFS, 32'h0012_0010);
    rd_chk(`BOUNDS_ONE_OFS, 32'h0012_0010);
    wr(`CONTROL_OFS, 32'hFFFF_FFFF);
    rd_chk(`CONTROL_OFS, `CTL_MASK);
    wr(`CONTROL_OFS, 32'h0000_0000);
    reg_io(1'b1, `BOUNDS_ONE_OFS, 2'h0, 32'hFFFF_FFFF, q, e);
    `CHK("narrow write error", 1'b1, e)
    reg_io(1'b0, `BOUNDS_ONE_OFS, 2'h1, 32'h0, q, e);
    `CHK("narrow read", 32'h0012_0010, q)
    reg_io(1'b0, 5'h14, `SIZE_WORD, 32'h0, q, e);
    `CHK("unmapped read", 32'h0000_0000, q)
    end_test("registers");

    // translation loaded before the selects open the window; the 192KB window ends at bus 0x0012_FFFF
    wr(`XLATE_ONE_OFS, 32'h1234_FFFC);
    wr(`CONTROL_OFS, 32'h0000_01A1);
    vme_chk(32'h0011_5678, 6'h0D, 1'b1, 2'b01, 32'h1235_5678, 1'b1);
    vme_chk(32'h0010_0000, 6'h0D, 1'b0, 2'b01, 32'h1234_0000, 1'b0);
    vme_chk(32'h0012_FFFF, 6'h0D, 1'b1, 2'b01, 32'h1236_FFFF, 1'b1);
    vme_chk(32'h0013_0000, 6'h0D, 1'b1, 2'b00, 32'h0, 1'b0);
    vme_chk(32'h000F_FFFF, 6'h0D, 1'b1, 2'b00, 32'h0, 1'b0);
    vme_chk(32'h0011_0000, 6'h09, 1'b1, 2'b00, 32'h0, 1'b0);
    vme_chk(32'h0011_0000, 6'h3D, 1'b1, 2'b00, 32'h0, 1'b0);
    wr(`CONTROL_OFS, 32'h0000_01B1);
    vme_chk(32'hAB11_5678, 6'h3D, 1'b1, 2'b01, 32'h1235_5678, 1'b1);
    end_test("replacement");

    for (k = 0; k < 4; k++) begin
      wr(`CONTROL_OFS, 32'h0000_00A0 | (32'h1 << k));
      vme_chk(32'h0011_0000, {4'b0011, 2'(k + 1)}, 1'b0, 2'b01, 32'h1235_0000, 1'b0);
      vme_chk(32'h0011_0000, {4'b0011, 2'(k + 2)}, 1'b0, 2'b00, 32'h0, 1'b0);
    end
    end_test("cycle kinds");

    wr(`CONTROL_OFS, 32'h0000_09A1);
    vme_chk(32'h0011_5678, 6'h0D, 1'b1, 2'b01, 32'h1245_5678, 1'b1);
    wr(`CONTROL_OFS, 32'h0000_09B1);
    vme_chk(32'hAB11_5678, 6'h3D, 1'b1, 2'b01, 32'h1245_5678, 1'b1);
    wr(`CONTROL_OFS, 32'h0000_0821);
    vme_chk(32'h0011_5678, 6'h0D, 1'b1, 2'b00, 32'h0, 1'b0);
    wr(`CONTROL_OFS, 32'h0000_0900);
    vme_chk(32'h0011_5678, 6'h0D, 1'b1, 2'b00, 32'h0, 1'b0);
    wr(`XLATE_ONE_OFS, 32'h0000_0000);
    wr(`CONTROL_OFS, 32'h0000_01A1);
    vme_chk(32'h0011_5678, 6'h0D, 1'b1, 2'b01, 32'h0011_5678, 1'b1);
    end_test("adder one");

    wr(`BOUNDS_TWO_OFS, 32'h0020_0020);
    wr(`XLATE_TWO_OFS, 32'h5610_FFFF);
    wr(`CONTROL_OFS, 32'h0051_0000);
    vme_chk(32'hFF20_1234, 6'h39, 1'b1, 2'b10, 32'h5610_1234, 1'b0);
    wr(`CONTROL_OFS, 32'h0951_0000);
    vme_chk(32'hFF20_1234, 6'h39, 1'b1, 2'b10, 32'h5630_1234, 1'b1);
    end_test("window two");

    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(`CONTROL_OFS, 32'h0000_0000);
    rd_chk(`XLATE_TWO_OFS, 32'h0000_0000);
    vme_chk(32'h0020_1234, 6'h39, 1'b1, 2'b00, 32'h0, 1'b0);
    end_test("second reset");
    complete_run();
  end
endmodule
